//--- verilog/ams_mode_sel.sv
`timescale 1ns/10ps
module ams_mode_sel
  import ams_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire ams_pkg::ams_pins_t pins,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output ams_pkg::ams_mode_t mode,
  output ams_pkg::ams_drive_t drive,
  output logic bus_mode
);
  import ams_pkg::*;

  logic en_q;
  logic [7:0] instruction_byte_one;
  logic [7:0] instruction_byte_two;
  logic [7:0] ramp_step;
  logic [7:0] level;
  logic wr_pend;
  logic [7:0] addr_q;
  ams_mode_t next_mode;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // bus-mode strap latch
  // ------------------------------------------------------------
  // enable edge detect; pins are synchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= pins.chip_enable;
    end
  end

  // strap caught on the enable rising edge, kept until enable drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_mode <= 1'b0;
    end else if (pins.chip_enable && !en_q) begin
      bus_mode <= pins.address_strap_res;
    end else if (!pins.chip_enable) begin
      bus_mode <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  // zero wait states; always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q <= '0;
    end else if (hready) begin
      wr_pend <= hsel && htrans == AMS_HTRANS_NONSEQ && hwrite;
      addr_q <= haddr[7:0] & AMS_ADDR_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control bytes; cleared and write-locked while the chip is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instruction_byte_one <= AMS_IB_RST;
      instruction_byte_two <= AMS_IB_RST;
    end else if (!pins.chip_enable) begin
      instruction_byte_one <= AMS_IB_RST;
      instruction_byte_two <= AMS_IB_RST;
    end else if (wr_pend && bus_mode &&
                 {24'h00_0000, addr_q} == AMS_CTRL_OFS) begin
      instruction_byte_one <= hwdata[AMS_IB1_BIT +: 8];
      instruction_byte_two <= hwdata[AMS_IB2_BIT +: 8];
    end
  end

  // ramp speed stands in for the mute capacitor value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_step <= AMS_RAMP_STEP_RST;
    end else if (wr_pend && pins.chip_enable &&
                 {24'h00_0000, addr_q} == AMS_RAMP_OFS) begin
      ramp_step <= hwdata[7:0];
    end
  end

  // read mux on the address phase; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    case ({24'h00_0000, haddr[7:0] & AMS_ADDR_MASK})
      AMS_CTRL_OFS: begin
        next_rdata[AMS_IB1_BIT +: 8] = instruction_byte_one;
        next_rdata[AMS_IB2_BIT +: 8] = instruction_byte_two;
      end
      AMS_STAT_OFS: begin
        next_rdata[AMS_ST_MODE_LO +: 2] = mode;
        next_rdata[AMS_ST_BUS_BIT] = bus_mode;
        next_rdata[AMS_ST_LVL_LO +: 8] = level;
      end
      AMS_RAMP_OFS: next_rdata[7:0] = ramp_step;
      default: next_rdata = '0;
    endcase
  end

  // read data registered on the address phase, standing in the data
  // phase; a read right behind a write to the same word sees old data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans == AMS_HTRANS_NONSEQ &&
                 !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // unlisted bus combinations fall back to standby, the safe state
  always_comb begin
    next_mode = AMS_STANDBY;
    // stay off for the edge that latches the strap, so no stale mode
    if (!pins.chip_enable || !en_q) begin
      next_mode = AMS_OFF;
    end else if (!bus_mode) begin
      next_mode = pins.mute_select ? AMS_OPERATE : AMS_MUTE;
    end else if (pins.mute_select && instruction_byte_one[0] &&
                 !instruction_byte_two[0]) begin
      next_mode = AMS_OPERATE;
    end else if (!pins.mute_select && instruction_byte_one[0] &&
                 instruction_byte_two[0]) begin
      next_mode = AMS_MUTE;
    end else begin
      next_mode = AMS_STANDBY;
    end
  end

  // mode register; one cycle late while the strap latch settles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= AMS_OFF;
    end else begin
      case (next_mode)
        AMS_OFF, AMS_STANDBY, AMS_MUTE, AMS_OPERATE: mode <= next_mode;
        default: mode <= AMS_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------
  // output stage drive
  // ------------------------------------------------------------
  ams_ramp #(
    .WIDTH(8),
    .TICK_CYC(AMS_RAMP_TICK_CYC)
  ) u_ramp (
    .hclk(hclk),
    .hresetn(hresetn),
    .target_up(mode == AMS_OPERATE),
    .step(ramp_step),
    .level(level)
  );

  // bridges switch in mute and operate; muted audio fades to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
    end else begin
      drive.bridges_on <= (mode == AMS_MUTE) || (mode == AMS_OPERATE);
      drive.gain <= (mode == AMS_OFF) ? 8'h00 : level;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  off_when_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins.chip_enable |=> mode == AMS_OFF) else $error("not off");
  ib_locked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins.chip_enable |=> instruction_byte_one == AMS_IB_RST)
    else $error("control byte kept while off");
  strap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pins.chip_enable && $past(pins.chip_enable) |=> $stable(bus_mode))
    else $error("bus mode changed while enabled");
  strap_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(pins.chip_enable) |=> bus_mode == $past(pins.address_strap_res))
    else $error("strap not sampled");
  pin_mute_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !bus_mode && en_q && pins.chip_enable && !pins.mute_select
    |=> mode == AMS_MUTE) else $error("pin mode not mute");
  bus_oper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == AMS_OPERATE && $past(bus_mode) |-> $past(pins.mute_select)
    && $past(instruction_byte_one[0]) && !$past(instruction_byte_two[0]))
    else $error("operate without cause");
  bus_mute_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_mode && pins.chip_enable && !pins.mute_select &&
    instruction_byte_one[0] && instruction_byte_two[0]
    |=> mode == AMS_MUTE) else $error("bus mute missed");
  bus_stby_a: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_mode && pins.chip_enable && !pins.mute_select &&
    !instruction_byte_one[0] |=> mode == AMS_STANDBY)
    else $error("bus standby missed");
  mute_bridge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == AMS_MUTE |=> drive.bridges_on) else $error("bridges idle");

  cover_pin_op_c: cover property (@(posedge hclk) disable iff (!hresetn)
    !bus_mode && mode == AMS_OPERATE);
  cover_bus_op_c: cover property (@(posedge hclk) disable iff (!hresetn)
    bus_mode && mode == AMS_OPERATE);
  cover_bus_mute_c: cover property (@(posedge hclk) disable iff (!hresetn)
    bus_mode && mode == AMS_MUTE);
  cover_fade_c: cover property (@(posedge hclk) disable iff (!hresetn)
    mode == AMS_MUTE && level != 8'h00);

endmodule

//--- verilog/ams_pkg.sv
package ams_pkg;

  // ------------------------------------------------------------
  // bus map
  // ------------------------------------------------------------
  localparam logic [31:0] AMS_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] AMS_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] AMS_RAMP_OFS = 32'h0000_0008;
  localparam logic [7:0] AMS_ADDR_MASK = 8'h0F;

  // control register fields
  localparam int AMS_IB1_BIT = 0;
  localparam int AMS_IB2_BIT = 8;

  // status register fields
  localparam int AMS_ST_MODE_LO = 0;
  localparam int AMS_ST_BUS_BIT = 4;
  localparam int AMS_ST_LVL_LO = 8;

  // reset values
  localparam logic [7:0] AMS_IB_RST = 8'h00;
  localparam logic [7:0] AMS_RAMP_STEP_RST = 8'h01;

  // htrans codes
  localparam logic [1:0] AMS_HTRANS_NONSEQ = 2'b10;

  // ramp timing: one gain step every RAMP_TICK_NS
  localparam int AMS_CLK_NS = 25;
  localparam int AMS_RAMP_TICK_NS = 1000;
  localparam int AMS_RAMP_TICK_CYC =
    (AMS_RAMP_TICK_NS / AMS_CLK_NS < 1) ? 1 : AMS_RAMP_TICK_NS / AMS_CLK_NS;

  typedef enum logic [1:0] {
    AMS_OFF,
    AMS_STANDBY,
    AMS_MUTE,
    AMS_OPERATE
  } ams_mode_t;

  // pins from the host side
  typedef struct packed {
    logic chip_enable;
    logic mute_select;
    logic address_strap_res;  // high when a resistor sits on the strap
  } ams_pins_t;

  // drive to the output stage
  typedef struct packed {
    logic bridges_on;  // bridges switching (50 % idle when muted)
    logic [7:0] gain;  // audio gain level, 0 = suppressed
  } ams_drive_t;

endpackage

//--- verilog/ams_ramp.sv
`timescale 1ns/10ps
module ams_ramp
  import ams_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int TICK_CYC = AMS_RAMP_TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic target_up,
  input wire logic [WIDTH-1:0] step,
  output logic [WIDTH-1:0] level
);

  localparam logic [WIDTH-1:0] LMAX = {WIDTH{1'b1}};
  logic [15:0] tick_cnt;
  logic tick;

  // ------------------------------------------------------------
  // tick divider
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'd1;
      tick <= 1'b0;
    end
  end

  // gradual fade in and out, saturating; step models the pin capacitor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= '0;
    end else if (tick) begin
      if (target_up) begin
        level <= (LMAX - level < step) ? LMAX : level + step;
      end else begin
        level <= (level < step) ? '0 : level - step;
      end
    end
  end

  ramp_bounded_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tick |=> level == $past(level)) else $error("level moved off tick");

endmodule

//--- test/ams_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// host side: microcontroller that drives the mode pins
// ----------------------------------------------------------
module ams_host_model
  import ams_pkg::*;
(
  input wire logic hclk,
  output ams_pkg::ams_pins_t pins
);
  // power-up: enable low, strap grounded, mute selected
  initial begin
    pins = '0;
  end

  // pin levels change just after an edge, like a port write
  // operate needs enable and mute_select both high
  task automatic set(input logic en, input logic mute, input logic strap);
    @(posedge hclk);
    pins <= '{chip_enable: en, mute_select: mute,
              address_strap_res: strap};
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// bench for the mode selection block
// ----------------------------------------------------------
module tb_top;
  import ams_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bus_mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ams_pins_t pins;
  ams_mode_t mode;
  ams_drive_t drive;
  int errors, n_compared;
  logic [15:0] ctrl_tab [4] = '{16'h0101, 16'h0100, 16'h0000, 16'h0001};
  logic mute_tab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  ams_mode_t exp_tab [4] = '{AMS_MUTE, AMS_STANDBY, AMS_STANDBY,
                             AMS_OPERATE};

  ams_host_model host (.hclk(hclk), .pins(pins));

  // the single slave's hreadyout is the bus's hready
  ams_mode_sel dut (.hclk(hclk), .hresetn(hresetn), .pins(pins),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode(mode), .drive(drive), .bus_mode(bus_mode));

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------
  // compare, bus cycle and verdict
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // single word transfer; no wait count assumed, watchdog cuts hangs
  task automatic bus(input logic wr, input logic [31:0] addr,
                     input logic [31:0] data);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= AMS_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= data;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // mode seen both at the port and in status, latched strap in status only
  task automatic chk_stat(input ams_mode_t m, input logic b);
    bus(1'b0, AMS_STAT_OFS, 32'h0000_0000);
    check(rd & 32'h0000_0013, {27'h0, b, 2'b00, m});
    check({30'h0, mode}, {30'h0, m});
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    errors = 0;
    n_compared = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk_stat(AMS_OFF, 1'b0);
    bus(1'b0, AMS_RAMP_OFS, 32'h0000_0000);
    check(rd, {24'h0, AMS_RAMP_STEP_RST});
    bus(1'b0, 32'h0000_000C, 32'hFFFF_FFFF);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    // grounded strap: enable alone gives mute, bridges idling
    host.set(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge hclk);
    chk_stat(AMS_MUTE, 1'b0);
    check({31'h0, drive.bridges_on}, 32'h0000_0001);
    host.set(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge hclk);
    chk_stat(AMS_OPERATE, 1'b0);
    host.set(1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge hclk);
    chk_stat(AMS_OFF, 1'b0);
    $display("test pin mode done");
    // a control write while off must not count later
    host.set(1'b0, 1'b0, 1'b1);
    bus(1'b1, AMS_CTRL_OFS, 32'h0000_0101);
    host.set(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge hclk);
    chk_stat(AMS_STANDBY, 1'b1);
    for (int i = 0; i < 4; i++) begin
      host.set(1'b1, mute_tab[i], 1'b1);
      bus(1'b1, AMS_CTRL_OFS, {16'h0, ctrl_tab[i]});
      repeat (3) @(posedge hclk);
      chk_stat(exp_tab[i], 1'b1);
    end
    // gain must climb step by step, not jump to full scale
    repeat (100) @(posedge hclk);
    check(32'(drive.gain > 8'h00 && drive.gain < 8'h10), 32'h1);
    // strap moved while enabled is ignored
    host.set(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge hclk);
    chk_stat(AMS_OPERATE, 1'b1);
    $display("test bus mode done");
    give_verdict();
  end

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(25 * 20000);
    errors++;
    give_verdict();
  end
endmodule
